// >>> rtl/rx_port_register_paging.sv
`timescale 1ns/100ps
module rx_port_register_paging (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire rx_page_pkg::reg_req_t req,
  output logic                      ack,
  output logic [7:0]                rdata,
  input  wire logic [3:0][7:0]      port_rdata,
  output logic [3:0]                paged_wr,
  output logic [7:0]                paged_addr,
  output logic [7:0]                paged_wdata,
  input  wire logic [3:0]           csi_mode,
  input  wire logic [3:0]           twelve_bit_sel,
  input  wire logic [5:0]           ten_bit_type_code,
  input  wire logic [5:0]           twelve_bit_type_code,
  input  wire logic [3:0]           frame_start,
  input  wire logic [3:0]           long_packet,
  output logic [3:0][5:0]           packet_type
);
  import rx_page_pkg::*;

  page_sel_t        page_r  [NUM_SRC];
  page_sel_t        page_nxt[NUM_SRC];
  embed_ctl_t       embed_r  [NUM_PORTS];
  embed_ctl_t       embed_nxt[NUM_PORTS];
  logic [1:0]       cnt_r  [NUM_PORTS];
  logic [1:0]       cnt_nxt[NUM_PORTS];
  logic [3:0][5:0]  type_r, type_nxt;
  logic             ack_r, ack_nxt;
  logic [7:0]       rdata_r, rdata_nxt;
  logic [3:0]       pwr_r, pwr_nxt;
  logic [7:0]       paddr_r, paddr_nxt, pwdata_r, pwdata_nxt;

  logic [2:0]       src;
  logic [1:0]       phys;
  page_sel_t        sel;
  logic             in_paged;
  logic             wr_now;

  // unknown source codes fall back to the local copy
  assign src  = (req.src < 3'(NUM_SRC)) ? req.src : LOCAL_SRC;
  assign phys = (src == LOCAL_SRC) ? 2'h0 : 2'(src - 3'h1);
  assign sel  = page_r[src];
  assign in_paged = ((req.addr >= PAGED_LO_A) && (req.addr <= PAGED_HI_A))
                 || ((req.addr >= PAGED_LO_B) && (req.addr <= PAGED_HI_B));
  assign wr_now = req.valid && req.write;

  always_comb begin
    for (int s = 0; s < NUM_SRC; s++) begin
      page_nxt[s] = page_r[s];
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      embed_nxt[p] = embed_r[p];
    end
    ack_nxt    = req.valid;
    rdata_nxt  = rdata_r;
    pwr_nxt    = 4'h0;
    paddr_nxt  = paddr_r;
    pwdata_nxt = pwdata_r;
    if (wr_now && req.addr == PAGE_SEL_ADDR) begin
      // only the requesting source's copy moves
      page_nxt[src] = page_sel_t'(req.wdata[5:0]);
    end
    if (wr_now && req.addr == EMBED_TYPE_ADDR) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (sel.wr_en[p]) begin
          embed_nxt[p] = embed_ctl_t'(req.wdata);
        end
      end
    end
    if (wr_now && in_paged) begin
      pwr_nxt    = sel.wr_en;
      paddr_nxt  = req.addr;
      pwdata_nxt = req.wdata;
    end
    if (req.valid && !req.write) begin
      if (req.addr == PAGE_SEL_ADDR) begin
        rdata_nxt = {phys, sel.rd_port, sel.wr_en};
      end else if (req.addr == EMBED_TYPE_ADDR) begin
        rdata_nxt = embed_r[sel.rd_port];
      end else if (req.addr == STATUS1_ADDR) begin
        rdata_nxt = {sel.rd_port, port_rdata[sel.rd_port][5:0]};
      end else if (in_paged) begin
        rdata_nxt = port_rdata[sel.rd_port];
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      page_r[0] <= '{rd_port: 2'h0, wr_en: 4'h0};
      for (int k = 0; k < NUM_PORTS; k++) begin
        page_r[k+1].rd_port <= 2'(k);
        page_r[k+1].wr_en   <= 4'(4'h1 << k);
      end
      ack_r    <= 1'b0;
      rdata_r  <= 8'h00;
      pwr_r    <= 4'h0;
      paddr_r  <= 8'h00;
      pwdata_r <= 8'h00;
    end else begin
      for (int s = 0; s < NUM_SRC; s++) begin
        page_r[s] <= page_nxt[s];
      end
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
      pwr_r    <= pwr_nxt;
      paddr_r  <= paddr_nxt;
      pwdata_r <= pwdata_nxt;
    end
  end

  // per-port frame counting and type selection
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [5:0] raw_code;
    logic       tag;
    assign raw_code = twelve_bit_sel[p] ? twelve_bit_type_code
                                        : ten_bit_type_code;
    // saturating count keeps the tag off for long frames
    assign tag = !csi_mode[p] && (cnt_nxt[p] < embed_nxt[p].line_count);

    always_comb begin
      cnt_nxt[p] = cnt_r[p];
      if (frame_start[p]) begin
        cnt_nxt[p] = 2'h0;
      end else if (long_packet[p] && cnt_r[p] != 2'h3) begin
        cnt_nxt[p] = cnt_r[p] + 2'h1;
      end
      type_nxt[p] = tag ? embed_nxt[p].type_code
                        : raw_code;
    end

    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        cnt_r[p]   <= 2'h0;
        embed_r[p] <= embed_ctl_t'(EMBED_RESET);
        type_r[p]  <= 6'h00;
      end else begin
        cnt_r[p]   <= cnt_nxt[p];
        embed_r[p] <= embed_nxt[p];
        type_r[p]  <= type_nxt[p];
      end
    end

    // packet_type was registered from last cycle's mode, so look back
    embed_tag_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $past(reset_n) && !$past(csi_mode[p])
        && cnt_r[p] < embed_r[p].line_count
        |-> packet_type[p] == embed_r[p].type_code)
      else $error("embedded code not applied");
    csi_ignore_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $past(csi_mode[p]) && $past(reset_n)
        |-> packet_type[p] == $past(twelve_bit_sel[p] ?
            twelve_bit_type_code : ten_bit_type_code))
      else $error("csi mode used embedded code");
    frame_count_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      frame_start[p] |=> cnt_r[p] == 2'h0)
      else $error("frame start did not restart count");
    count_zero_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      $past(reset_n) && embed_r[p].line_count == 2'h0
        |-> packet_type[p] == $past(twelve_bit_sel[p] ?
            twelve_bit_type_code : ten_bit_type_code))
      else $error("line count zero still tagged");
    embed_write_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      wr_now && req.addr == EMBED_TYPE_ADDR && sel.wr_en[p]
        |=> embed_r[p] == $past(req.wdata))
      else $error("embedded register write lost");
    embed_block_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !(wr_now && req.addr == EMBED_TYPE_ADDR && sel.wr_en[p])
        |=> embed_r[p] == $past(embed_r[p]))
      else $error("embedded register changed unasked");
  end

  assign ack         = ack_r;
  assign rdata       = rdata_r;
  assign paged_wr    = pwr_r;
  assign paged_addr  = paddr_r;
  assign paged_wdata = pwdata_r;
  assign packet_type = type_r;

  paged_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    wr_now && in_paged |=> paged_wr == $past(sel.wr_en))
    else $error("paged write enables wrong");
  no_stray_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(wr_now && in_paged) |=> paged_wr == 4'h0)
    else $error("paged write without request");
  read_page_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req.valid && !req.write && in_paged && req.addr != STATUS1_ADDR
      |=> rdata == $past(port_rdata[sel.rd_port]))
    else $error("paged read from wrong port");
  phys_port_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req.valid && !req.write && req.addr == PAGE_SEL_ADDR
      |=> rdata[7:6] == $past(phys))
    else $error("physical port field wrong");
  status_idx_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    req.valid && !req.write && req.addr == STATUS1_ADDR
      |=> rdata[7:6] == $past(sel.rd_port))
    else $error("status read index wrong");
  remote_default_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> page_r[1].wr_en == 4'h1 && page_r[4].wr_en == 4'h8
      && page_r[3].rd_port == 2'h2 && page_r[0] == 6'h00)
    else $error("page select defaults wrong");
  read_default_a: assert property (@(posedge mclk)
    $rose(reset_n) |-> page_r[0].rd_port == 2'h0
      && page_r[1].rd_port == 2'h0 && page_r[2].rd_port == 2'h1
      && page_r[4].rd_port == 2'h3)
    else $error("read index defaults wrong");

  // each source's copy moves only on its own write
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    page_keep_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      !(wr_now && req.addr == PAGE_SEL_ADDR && src == 3'(s))
        |=> page_r[s] == $past(page_r[s]))
      else $error("other source page select changed");
    page_load_a: assert property (@(posedge mclk)
      disable iff (!reset_n)
      wr_now && req.addr == PAGE_SEL_ADDR && src == 3'(s)
        |=> page_r[s] == $past(req.wdata[5:0]))
      else $error("page select write lost");
  end
  ack_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
    req.valid |=> ack ##1 (ack == $past(req.valid)))
    else $error("access not answered");
endmodule

// >>> rtl/rx_page_pkg.sv
package rx_page_pkg;
  localparam int          NUM_PORTS       = 4;
  localparam int          NUM_SRC         = 5;
  localparam logic [7:0]  EMBED_TYPE_ADDR = 8'h4b;
  localparam logic [7:0]  PAGE_SEL_ADDR   = 8'h4c;
  localparam logic [7:0]  PAGED_LO_A      = 8'h4d;
  localparam logic [7:0]  PAGED_HI_A      = 8'h7f;
  localparam logic [7:0]  PAGED_LO_B      = 8'hd0;
  localparam logic [7:0]  PAGED_HI_B      = 8'hdf;
  localparam logic [7:0]  STATUS1_ADDR    = 8'h4d;
  localparam logic [7:0]  EMBED_RESET     = 8'h12;
  localparam logic [2:0]  LOCAL_SRC       = 3'h0;
  localparam int          PHYS_POS        = 6;
  localparam int          RD_POS          = 4;
  localparam int          COUNT_POS       = 6;

  // src 0 is local i2c, src 1+k is the back control channel of port k
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] src;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] rd_port;
    logic [3:0] wr_en;
  } page_sel_t;

  typedef struct packed {
    logic [1:0] line_count;
    logic [5:0] type_code;
  } embed_ctl_t;
endpackage

// >>> tb/port_block_model.sv
`timescale 1ns/100ps
module port_block_model (
  input  wire logic            mclk,
  input  wire logic [7:0]      addr,
  input  wire logic [3:0]      wr,
  input  wire logic [7:0]      waddr,
  input  wire logic [7:0]      wdata,
  output logic      [3:0][7:0] rdata
);
  logic [7:0] mem [4][256];

  initial begin
    foreach (mem[p, a]) mem[p][a] = 8'h00;
  end

  // each block takes only its own strobe, so broadcasts land in unison
  always @(posedge mclk) begin
    for (int p = 0; p < 4; p++) begin
      if (wr[p]) begin
        mem[p][waddr] <= wdata;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rdata[p] = mem[p][addr];
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rx_page_pkg::*;
  logic            mclk = 1'b0;
  logic            reset_n = 1'b0;
  reg_req_t        req = '0;
  logic            ack;
  logic [7:0]      rdata, paged_addr, paged_wdata, rv;
  logic [3:0]      paged_wr, pw, fs = 4'h0, lp = 4'h0;
  logic [3:0]      csi = 4'h0;
  logic [3:0][7:0] prd;
  logic [3:0][5:0] pt;
  logic [7:0]      ex [4] = '{8'h33, 8'h00, 8'h5a, 8'h00};
  int              errors = 0;
  int              compares = 0;

  always #20 mclk = ~mclk;

  port_block_model pm (.mclk(mclk), .addr(req.addr), .wr(paged_wr),
    .waddr(paged_addr), .wdata(paged_wdata), .rdata(prd));

  rx_port_register_paging DUT (.mclk(mclk), .reset_n(reset_n), .req(req),
    .ack(ack), .rdata(rdata), .port_rdata(prd), .paged_wr(paged_wr),
    .paged_addr(paged_addr), .paged_wdata(paged_wdata), .csi_mode(csi),
    .twelve_bit_sel(4'h2), .ten_bit_type_code(6'h2b),
    .twelve_bit_type_code(6'h2c), .frame_start(fs), .long_packet(lp),
    .packet_type(pt));

  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic acc(input logic [2:0] s, input logic w,
                     input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, w, a, d, s};
    @(posedge mclk);
    req.valid <= 1'b0;
    #1;
    while (ack !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 4) begin
      errors++;
      $display("ERROR t=%0t access not answered", $time);
      test_done();
    end
    rv = rdata;
    pw = paged_wr;
  endtask

  // one pulse, then let the counters and the registered type settle
  task automatic pulse(input logic [3:0] f, input logic [3:0] l);
    @(posedge mclk);
    fs <= f;
    lp <= l;
    @(posedge mclk);
    fs <= 4'h0;
    lp <= 4'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    acc(0, 0, 8'h4c, 0);
    chk(rv, 8'h00);
    for (int k = 0; k < 4; k++) begin
      acc(3'(k + 1), 0, 8'h4c, 0);
      chk(rv, {2'(k), 2'(k), 4'h1 << k});
    end
    acc(0, 0, 8'h4b, 0);
    chk(rv, 8'h12);
    $display("test defaults done");
    acc(0, 1, 8'h4c, 8'hd5);
    acc(0, 0, 8'h4c, 0);
    chk(rv, 8'h15);
    acc(1, 0, 8'h4c, 0);
    chk(rv, 8'h01);
    acc(0, 1, 8'h50, 8'h5a);
    chk({4'h0, pw}, 8'h05);
    chk(paged_addr, 8'h50);
    chk(paged_wdata, 8'h5a);
    acc(0, 1, 8'hdf, 8'h66);
    chk({4'h0, pw}, 8'h05);
    acc(0, 1, 8'h80, 8'h77);
    chk({4'h0, pw}, 8'h00);
    acc(1, 1, 8'h50, 8'h33);
    chk({4'h0, pw}, 8'h01);
    for (int r = 0; r < 4; r++) begin
      acc(0, 1, 8'h4c, {2'h0, 2'(r), 4'h5});
      acc(0, 0, 8'h50, 0);
      chk(rv, ex[r]);
      acc(0, 0, 8'h4d, 0);
      chk({6'h0, rv[7:6]}, 8'(r));
    end
    acc(0, 1, 8'h4c, 8'h00);
    acc(0, 1, 8'h50, 8'hff);
    chk({4'h0, pw}, 8'h00);
    $display("test paging done");
    acc(0, 1, 8'h4c, 8'h01);
    acc(0, 1, 8'h4b, 8'h95);
    acc(0, 0, 8'h4b, 0);
    chk(rv, 8'h95);
    acc(0, 1, 8'h4c, 8'h11);
    acc(0, 0, 8'h4b, 0);
    chk(rv, 8'h12);
    $display("test embedded register done");
    pulse(4'h3, 4'h0);
    chk({2'h0, pt[0]}, 8'h15);
    chk({2'h0, pt[1]}, 8'h2c);
    pulse(4'h0, 4'h1);
    chk({2'h0, pt[0]}, 8'h15);
    pulse(4'h0, 4'h1);
    chk({2'h0, pt[0]}, 8'h2b);
    pulse(4'h1, 4'h0);
    chk({2'h0, pt[0]}, 8'h15);
    @(posedge mclk);
    csi <= 4'h1;
    pulse(4'h1, 4'h0);
    chk({2'h0, pt[0]}, 8'h2b);
    $display("test packet path done");
    test_done();
  end
endmodule
